// File: rtl/e1_perf_monitor_prbs_txpayload_regs.sv
// Register slice: overflow flags, interrupt, pattern test setup and indirect payload access
// Operation
// RL1 - Set flag bit 7 on pattern error, bit 6 on tx far-end block error overflow.
// RL2 - Set flag bit 5 on far-end block error, bit 4 on tx CRC error overflow.
// RL3 - Set flag bit 3 on alignment change, bit 2 on out-of-frame overflow.
// RL4 - Set flag bit 1 on frame error, bit 0 on CRC error overflow.
// RL5 - Second flag register bit 0 flags line code violation overflow; rest reserved.
// RL6 - Overflow flags stay set until software writes one to them.
// RL7 - Line violation flag drives low-active interrupt only when its enable is one.
// RL8 - Mode 00 takes all 32 timeslots, ignoring per-timeslot selection.
// RL9 - Mode 01 takes whole selected timeslots only.
// RL10 - Mode 10 takes seven MSBs of selected timeslots; 11 is reserved.
// RL11 - Direction 0 generates on transmit, checks receive; 1 is the reverse.
// RL12 - Pattern engine starts only on a 0-to-1 edge of the start bit.
// RL13 - Busy reads one during an indirect access; software waits for zero.
// RL14 - Control bit 7 picks indirect direction: 0 writes, 1 reads.
// RL15 - Software uses seven-bit addresses within the valid indirect ranges.
// RL16 - For a write, software loads data before writing the control register.
// RL17 - For a read, control written with bit 7 set; data register gets byte.
// RL18 - Each first-register flag interrupts only when its same-position enable is one.
// RL19 - Control write launches access and sets busy; busy clears at completion.
// RL20 - Writing zero leaves flags unchanged; reserved bits read zero, ignore writes.
//
// The AXI4-Lite slave port was decided locally.
`default_nettype none
`include "e1_perf_monitor_defines.svh"
module e1_perf_monitor_prbs_txpayload_regs
    import e1_perf_monitor_pkg::*;
(
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite slave
    input  wire logic [11:0] awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    input  wire logic [11:0] araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    // Counter overflow events
    input  wire logic [7:0]  ovf_event,
    input  wire logic        lcv_ovf_event,
    // Interrupt
    output logic             irq_n,
    // Pattern generator/detector control
    output logic [1:0]       pattern_test_mode,
    output logic             pattern_direction,
    output logic             pattern_start,
    output logic             all_timeslots,
    output logic             msb7_only,
    // Transmit payload control memory port
    output logic             ind_req,
    output logic             indirect_read_not_write,
    output logic [6:0]       ind_addr,
    output logic [7:0]       ind_wdata,
    input  wire logic        ind_ack,
    input  wire logic [7:0]  ind_rdata
);
    logic        aw_hold_q;
    logic [11:0] aw_addr_q;
    logic        w_hold_q;
    logic [31:0] w_data_q;
    logic [3:0]  w_strb_q;
    logic        bvalid_q;
    logic [1:0]  bresp_q;
    logic        rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0]  rresp_q;
    byte_t       irq_en0_q;
    logic        lcv_irq_en_q;
    byte_t       flags0_q;
    logic        lcv_flag_q;
    logic [1:0]  mode_q;
    logic        dir_q;
    logic        start_q;
    logic        start_prev_q;
    logic        all_ts_q;
    logic        msb7_q;
    byte_t       ctrl_q;
    byte_t       data_q;
    logic        busy_q;
    logic        irq_n_q;

    logic        aw_fire;
    logic        w_fire;
    logic        wr_commit;
    logic [11:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0]  wr_strb;
    reg_index_t  wr_idx;
    reg_index_t  rd_idx;
    logic        wr_en;
    byte_t       wr_byte;
    byte_t       clr0;
    logic        clr1;
    logic        ctrl_wr;
    logic        wr_mapped;
    logic        rd_mapped;
    byte_t       rd_byte;

    // Write channel: address and data accepted in either order
    assign awready   = !aw_hold_q && !bvalid_q;
    assign wready    = !w_hold_q && !bvalid_q;
    assign aw_fire   = awvalid && awready;
    assign w_fire    = wvalid && wready;
    assign wr_commit = (aw_hold_q || aw_fire) && (w_hold_q || w_fire) && !bvalid_q;
    assign wr_addr   = aw_hold_q ? aw_addr_q : awaddr;
    assign wr_data   = w_hold_q ? w_data_q : wdata;
    assign wr_strb   = w_hold_q ? w_strb_q : wstrb;
    assign wr_idx    = wr_addr[`IDX_MSB:`IDX_LSB];
    assign wr_byte   = wr_data[`BYTE_MSB:0];
    assign wr_en     = wr_commit && wr_strb[0];

    always_comb begin
        case (wr_idx)
            `IDX_IRQ_EN0, `IDX_IRQ_EN1, `IDX_FLAGS0, `IDX_FLAGS1,
            `IDX_TEST_CFG, `IDX_ACC_STATUS, `IDX_ACC_CTRL,
            `IDX_ACC_DATA: wr_mapped = 1'b1;
            default:       wr_mapped = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_q <= 1'b0;
            aw_addr_q <= 12'h000;
        end else if (wr_commit) begin
            aw_hold_q <= 1'b0;
        end else if (aw_fire) begin
            aw_hold_q <= 1'b1;
            aw_addr_q <= awaddr;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_hold_q <= 1'b0;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
        end else if (wr_commit) begin
            w_hold_q <= 1'b0;
        end else if (w_fire) begin
            w_hold_q <= 1'b1;
            w_data_q <= wdata;
            w_strb_q <= wstrb;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
            bresp_q  <= `RESP_OKAY;
        end else if (wr_commit) begin
            bvalid_q <= 1'b1;
            bresp_q  <= wr_mapped ? `RESP_OKAY : `RESP_SLVERR;
        end else if (bready) begin
            bvalid_q <= 1'b0;
        end
    end

    assign bvalid = bvalid_q;
    assign bresp  = bresp_q;

    // Read channel: data one cycle after the address, no read side effects
    assign arready = !rvalid_q;
    assign rd_idx  = araddr[`IDX_MSB:`IDX_LSB];

    always_comb begin
        rd_mapped = 1'b1;
        rd_byte   = `BYTE_ZERO;
        case (rd_idx)
            `IDX_IRQ_EN0:    rd_byte = irq_en0_q;
            `IDX_IRQ_EN1:    rd_byte[`BIT_LCV] = lcv_irq_en_q;
            `IDX_FLAGS0:     rd_byte = flags0_q;
            `IDX_FLAGS1:     rd_byte[`BIT_LCV] = lcv_flag_q; // RL20
            `IDX_TEST_CFG:   rd_byte = {4'h0, mode_q, dir_q, start_q};
            `IDX_ACC_STATUS: rd_byte[`BIT_BUSY] = busy_q; // RL13
            `IDX_ACC_CTRL:   rd_byte = ctrl_q;
            `IDX_ACC_DATA:   rd_byte = data_q;
            default:         rd_mapped = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h0000_0000;
            rresp_q  <= `RESP_OKAY;
        end else if (arvalid && arready) begin
            rvalid_q <= 1'b1;
            rdata_q  <= {24'h00_0000, rd_byte};
            rresp_q  <= rd_mapped ? `RESP_OKAY : `RESP_SLVERR;
        end else if (rready) begin
            rvalid_q <= 1'b0;
        end
    end

    assign rvalid = rvalid_q;
    assign rdata  = rdata_q;
    assign rresp  = rresp_q;

    // Interrupt enables
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_en0_q    <= `BYTE_ZERO;
            lcv_irq_en_q <= 1'b0;
        end else if (wr_en && wr_idx == `IDX_IRQ_EN0) begin
            irq_en0_q <= wr_byte;
        end else if (wr_en && wr_idx == `IDX_IRQ_EN1) begin
            lcv_irq_en_q <= wr_byte[`BIT_LCV];
        end
    end

    // Sticky overflow flags, write one to clear, a new event wins
    assign clr0 = (wr_en && wr_idx == `IDX_FLAGS0) ? wr_byte : `BYTE_ZERO;
    assign clr1 = wr_en && wr_idx == `IDX_FLAGS1 && wr_byte[`BIT_LCV];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flags0_q   <= `BYTE_ZERO;
            lcv_flag_q <= 1'b0;
        end else begin
            flags0_q   <= ovf_event | (flags0_q & ~clr0); // RL1 RL2 RL3 RL4 RL6 RL20
            lcv_flag_q <= lcv_ovf_event | (lcv_flag_q & !clr1); // RL5 RL6
        end
    end

    // Low-active interrupt from enabled flags
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_n_q <= 1'b1;
        end else begin
            irq_n_q <= !(|(flags0_q & irq_en0_q) || (lcv_flag_q && lcv_irq_en_q)); // RL7 RL18
        end
    end

    assign irq_n = irq_n_q;

    // Pattern test configuration; a reserved mode write keeps the old mode
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_q  <= `MODE_UNFRAMED;
            all_ts_q <= 1'b1;
            msb7_q  <= 1'b0;
            dir_q   <= 1'b0;
            start_q <= 1'b0;
        end else if (wr_en && wr_idx == `IDX_TEST_CFG) begin
            if (wr_byte[`MODE_MSB:`MODE_LSB] != `MODE_RESERVED) begin
                mode_q   <= wr_byte[`MODE_MSB:`MODE_LSB]; // RL10
                all_ts_q <= wr_byte[`MODE_MSB:`MODE_LSB] == `MODE_UNFRAMED; // RL8 RL9
                msb7_q   <= wr_byte[`MODE_MSB:`MODE_LSB] == `MODE_MSB7; // RL10
            end
            dir_q   <= wr_byte[`BIT_DIR]; // RL11
            start_q <= wr_byte[`BIT_START];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            start_prev_q <= 1'b0;
        end else begin
            start_prev_q <= start_q;
        end
    end

    assign pattern_start     = start_q && !start_prev_q; // RL12
    assign pattern_test_mode = mode_q;
    assign pattern_direction = dir_q; // RL11
    assign all_timeslots     = all_ts_q; // RL8 RL9
    assign msb7_only         = msb7_q; // RL10

    // Indirect access to the transmit payload control memory
    assign ctrl_wr = wr_en && wr_idx == `IDX_ACC_CTRL && !busy_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_q <= `BYTE_ZERO;
            busy_q <= 1'b0;
        end else if (ctrl_wr) begin
            ctrl_q <= wr_byte; // RL14
            busy_q <= 1'b1; // RL19
        end else if (busy_q && ind_ack) begin
            busy_q <= 1'b0; // RL13 RL19
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            data_q <= `BYTE_ZERO;
        end else if (busy_q && ind_ack && ctrl_q[`BIT_RNW]) begin
            data_q <= ind_rdata; // RL17
        end else if (wr_en && wr_idx == `IDX_ACC_DATA && !busy_q) begin
            data_q <= wr_byte; // RL16
        end
    end

    assign ind_req                 = busy_q;
    assign indirect_read_not_write = ctrl_q[`BIT_RNW]; // RL14
    assign ind_addr                = ctrl_q[`ADDR_MSB:0]; // RL15
    assign ind_wdata               = data_q;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    AST_PATTERN_TXFAR: assert property ( // RL1
        (ovf_event[`BIT_PATTERN_ERR] |=> flags0_q[`BIT_PATTERN_ERR]) and
        (ovf_event[`BIT_TX_FAR_BLK] |=> flags0_q[`BIT_TX_FAR_BLK]))
        else $error("pattern or tx far-end flag not set");
    AST_FAR_TXCRC: assert property ( // RL2
        (ovf_event[`BIT_FAR_BLK] |=> flags0_q[`BIT_FAR_BLK]) and
        (ovf_event[`BIT_TX_CRC] |=> flags0_q[`BIT_TX_CRC]))
        else $error("far-end or tx crc flag not set");
    AST_OOF: assert property ( // RL3
        (ovf_event[`BIT_OOF] |=> flags0_q[`BIT_OOF] [*1]) and
        (ovf_event[`BIT_ALIGN_CHG] |=> flags0_q[`BIT_ALIGN_CHG]))
        else $error("out-of-frame or alignment flag not set");
    AST_LCV_SET: assert property ( // RL5
        lcv_ovf_event |=> lcv_flag_q)
        else $error("line violation flag not set");
    AST_STICKY: assert property ( // RL6
        flags0_q[`BIT_CRC_ERR] && !clr0[`BIT_CRC_ERR] |=> flags0_q[`BIT_CRC_ERR])
        else $error("crc flag dropped without clear");
    AST_LCV_IRQ: assert property ( // RL7
        lcv_flag_q && lcv_irq_en_q |=> !irq_n)
        else $error("enabled line violation flag gave no interrupt");
    AST_IRQ_CAUSE: assert property ( // RL18
        !irq_n |-> $past(|(flags0_q & irq_en0_q) || (lcv_flag_q && lcv_irq_en_q)))
        else $error("interrupt without enabled flag");
    AST_START_PULSE: assert property ( // RL12
        pattern_start |=> !pattern_start)
        else $error("start pulse longer than one cycle");
    AST_MODE_LEGAL: assert property ( // RL10
        pattern_test_mode != `MODE_RESERVED)
        else $error("reserved pattern mode in use");
    AST_BUSY_SET: assert property ( // RL19
        ctrl_wr |=> busy_q && ind_req)
        else $error("busy not set by control write");
    AST_READ_DATA: assert property ( // RL17
        busy_q && ind_ack && ctrl_q[`BIT_RNW] |=> !busy_q && data_q == $past(ind_rdata))
        else $error("indirect read data not loaded");

    COV_FLAG_CLEAR: cover property (flags0_q[`BIT_OOF] ##1 !flags0_q[`BIT_OOF]);
    COV_IND_READ: cover property (ctrl_wr ##[1:20] (ind_ack && ctrl_q[`BIT_RNW]));
    COV_START: cover property (pattern_start);
    COV_IRQ: cover property (irq_n ##1 !irq_n);
endmodule : e1_perf_monitor_prbs_txpayload_regs
`default_nettype wire

// File: common/e1_perf_monitor_defines.svh
// Register indices, field positions and bus codes of the monitor/test register slice
`ifndef E1_PERF_MONITOR_DEFINES_SVH
`define E1_PERF_MONITOR_DEFINES_SVH
`define IDX_IRQ_EN0     10'h0c3
`define IDX_IRQ_EN1     10'h0c4
`define IDX_FLAGS0      10'h0c5
`define IDX_FLAGS1      10'h0c6
`define IDX_TEST_CFG    10'h0c7
`define IDX_ACC_STATUS  10'h0c8
`define IDX_ACC_CTRL    10'h0c9
`define IDX_ACC_DATA    10'h0ca
`define IDX_MSB         11
`define IDX_LSB         2
`define BIT_PATTERN_ERR 7
`define BIT_TX_FAR_BLK  6
`define BIT_FAR_BLK     5
`define BIT_TX_CRC      4
`define BIT_ALIGN_CHG   3
`define BIT_OOF         2
`define BIT_FRAME_ERR   1
`define BIT_CRC_ERR     0
`define BIT_LCV         0
`define BIT_START       0
`define BIT_DIR         1
`define MODE_LSB        2
`define MODE_MSB        3
`define BIT_BUSY        0
`define BIT_RNW         7
`define ADDR_MSB        6
`define BYTE_MSB        7
`define BYTE_ZERO       8'h00
`define MODE_RESERVED   2'h3
`define MODE_UNFRAMED   2'h0
`define MODE_MSB7       2'h2
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2
`endif

// File: common/e1_perf_monitor_pkg.sv
// Types shared by the monitor/test register slice
`default_nettype none
package e1_perf_monitor_pkg;
    typedef logic [7:0] byte_t;
    typedef logic [9:0] reg_index_t;
endpackage : e1_perf_monitor_pkg
`default_nettype wire

// File: sim/e1_perf_monitor_prbs_txpayload_regs_bench.sv
// Self-checking bench for the monitor/test register slice
`default_nettype none
`include "e1_perf_monitor_defines.svh"
module e1_perf_monitor_prbs_txpayload_regs_bench
    import e1_perf_monitor_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic        aclk, aresetn;
    logic [11:0] awaddr, araddr;
    logic        awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready;
    logic [31:0] wdata, rdata;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp;
    logic [7:0]  ovf_event, ind_wdata, ind_rdata;
    logic        lcv_ovf_event, irq_n, ind_req, ind_ack, indirect_read_not_write;
    logic [1:0]  pattern_test_mode;
    logic        pattern_direction, pattern_start, all_timeslots, msb7_only;
    logic [6:0]  ind_addr;
    int          miscompares, comparisons, starts;

    e1_perf_monitor_prbs_txpayload_regs i_e1_perf_monitor_prbs_txpayload_regs (
        .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .ovf_event(ovf_event), .lcv_ovf_event(lcv_ovf_event), .irq_n(irq_n),
        .pattern_test_mode(pattern_test_mode), .pattern_direction(pattern_direction),
        .pattern_start(pattern_start), .all_timeslots(all_timeslots), .msb7_only(msb7_only),
        .ind_req(ind_req), .indirect_read_not_write(indirect_read_not_write),
        .ind_addr(ind_addr), .ind_wdata(ind_wdata), .ind_ack(ind_ack), .ind_rdata(ind_rdata)
    );

    initial begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end

    always @(posedge aclk) begin
        if (pattern_start === 1'b1) starts++;
    end

    task automatic test_done;
        if (miscompares == 0 && comparisons > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : test_done

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Offers address and data together, releases each at its own handshake edge
    task automatic wr_raw(input logic [9:0] idx, input logic [7:0] d, output logic [1:0] r);
        logic ha, hw, hb;
        @(posedge aclk);
        awaddr  <= {idx, 2'h0};
        wdata   <= {24'h00_0000, d};
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        hb = 1'b0;
        while (!hb) begin
            @(posedge aclk);
            ha = awvalid && awready;
            hw = wvalid && wready;
            hb = bvalid;
            r  = bresp;
            if (ha) awvalid <= 1'b0;
            if (hw) wvalid <= 1'b0;
            if (hb) bready <= 1'b0;
        end
    endtask : wr_raw

    task automatic rd_raw(input logic [9:0] idx, output logic [31:0] d, output logic [1:0] r);
        logic ha, hr;
        @(posedge aclk);
        araddr  <= {idx, 2'h0};
        arvalid <= 1'b1;
        rready  <= 1'b1;
        hr = 1'b0;
        while (!hr) begin
            @(posedge aclk);
            ha = arvalid && arready;
            hr = rvalid;
            d  = rdata;
            r  = rresp;
            if (ha) arvalid <= 1'b0;
            if (hr) rready <= 1'b0;
        end
    endtask : rd_raw

    task automatic wr(input logic [9:0] idx, input logic [7:0] d);
        logic [1:0] r;
        wr_raw(idx, d, r);
        chk({30'h0, r}, {30'h0, `RESP_OKAY});
    endtask : wr

    task automatic rdc(input logic [9:0] idx, input logic [7:0] exp);
        logic [31:0] d;
        logic [1:0]  r;
        rd_raw(idx, d, r);
        chk({30'h0, r}, {30'h0, `RESP_OKAY});
        chk(d, {24'h0, exp});
    endtask : rdc

    task automatic ack(input logic [7:0] d);
        @(posedge aclk);
        ind_ack   <= 1'b1;
        ind_rdata <= d;
        @(posedge aclk);
        ind_ack <= 1'b0;
        repeat (2) @(posedge aclk);
    endtask : ack

    task automatic t_reset_unmapped;
        logic [31:0] d;
        logic [1:0]  r;
        rdc(`IDX_FLAGS0, 8'h00);
        rdc(`IDX_ACC_STATUS, 8'h00);
        rdc(`IDX_ACC_CTRL, 8'h00);
        rd_raw(10'h0d0, d, r);
        chk({30'h0, r}, {30'h0, `RESP_SLVERR});
        wr_raw(10'h0d0, 8'hff, r);
        chk({30'h0, r}, {30'h0, `RESP_SLVERR});
    endtask : t_reset_unmapped

    task automatic t_flags0;
        for (int i = 0; i < 8; i++) begin
            @(posedge aclk) ovf_event <= 8'h01 << i;
            @(posedge aclk) ovf_event <= 8'h00;
            rdc(`IDX_FLAGS0, 8'h01 << i);
            wr(`IDX_FLAGS0, 8'h00);
            rdc(`IDX_FLAGS0, 8'h01 << i);
            chk({31'h0, irq_n}, 32'h1);
            wr(`IDX_FLAGS0, 8'h01 << i);
            rdc(`IDX_FLAGS0, 8'h00);
        end
        wr(`IDX_IRQ_EN0, 8'h80);
        rdc(`IDX_IRQ_EN0, 8'h80);
        @(posedge aclk) ovf_event <= 8'h40;
        @(posedge aclk) ovf_event <= 8'h80;
        @(posedge aclk) ovf_event <= 8'h00;
        repeat (2) @(posedge aclk);
        chk({31'h0, irq_n}, 32'h0);
        wr(`IDX_FLAGS0, 8'h80);
        repeat (2) @(posedge aclk);
        chk({31'h0, irq_n}, 32'h1);
        wr(`IDX_FLAGS0, 8'h40);
    endtask : t_flags0

    task automatic t_lcv;
        @(posedge aclk) lcv_ovf_event <= 1'b1;
        @(posedge aclk) lcv_ovf_event <= 1'b0;
        rdc(`IDX_FLAGS1, 8'h01);
        chk({31'h0, irq_n}, 32'h1);
        wr(`IDX_IRQ_EN1, 8'hff);
        rdc(`IDX_IRQ_EN1, 8'h01);
        repeat (2) @(posedge aclk);
        chk({31'h0, irq_n}, 32'h0);
        wr(`IDX_FLAGS1, 8'hfe);
        rdc(`IDX_FLAGS1, 8'h01);
        wr(`IDX_FLAGS1, 8'hff);
        rdc(`IDX_FLAGS1, 8'h00);
        repeat (2) @(posedge aclk);
        chk({31'h0, irq_n}, 32'h1);
    endtask : t_lcv

    task automatic t_pattern;
        for (int m = 0; m < 3; m++) begin
            wr(`IDX_TEST_CFG, {4'h0, m[1:0], 2'b00});
            chk({30'h0, pattern_test_mode}, m);
            chk({31'h0, all_timeslots}, {31'h0, m == 0});
            chk({31'h0, msb7_only}, {31'h0, m == 2});
        end
        wr(`IDX_TEST_CFG, 8'h0e);
        chk({30'h0, pattern_test_mode}, 32'h2);
        chk({31'h0, pattern_direction}, 32'h1);
        rdc(`IDX_TEST_CFG, 8'h0a);
        wr(`IDX_TEST_CFG, 8'h04);
        chk({31'h0, pattern_direction}, 32'h0);
        starts = 0;
        wr(`IDX_TEST_CFG, 8'h05);
        wr(`IDX_TEST_CFG, 8'h05);
        repeat (2) @(posedge aclk);
        chk(starts, 32'h1);
        wr(`IDX_TEST_CFG, 8'h04);
        wr(`IDX_TEST_CFG, 8'h07);
        repeat (2) @(posedge aclk);
        chk(starts, 32'h2);
        rdc(`IDX_TEST_CFG, 8'h07);
    endtask : t_pattern

    task automatic t_indirect;
        wr(`IDX_ACC_DATA, 8'h5a);
        wr(`IDX_ACC_CTRL, 8'h41);
        chk({31'h0, ind_req}, 32'h1);
        chk({24'h0, indirect_read_not_write, ind_addr}, 32'h41);
        chk({24'h0, ind_wdata}, 32'h5a);
        rdc(`IDX_ACC_STATUS, 8'h01);
        wr(`IDX_ACC_CTRL, 8'hc2);
        chk({25'h0, ind_addr}, 32'h41);
        wr(`IDX_ACC_DATA, 8'hee);
        chk({24'h0, ind_wdata}, 32'h5a);
        ack(8'h00);
        chk({31'h0, ind_req}, 32'h0);
        rdc(`IDX_ACC_STATUS, 8'h00);
        wr(`IDX_ACC_CTRL, 8'hd5);
        chk({24'h0, indirect_read_not_write, ind_addr}, 32'hd5);
        ack(8'hc3);
        rdc(`IDX_ACC_DATA, 8'hc3);
        rdc(`IDX_ACC_CTRL, 8'hd5);
    endtask : t_indirect

    initial begin
        repeat (5000) @(posedge aclk);
        miscompares++;
        test_done;
    end

    initial begin
        aresetn       = 1'b0;
        awaddr        = '0;
        awvalid       = 1'b0;
        wdata         = '0;
        wstrb         = 4'hf;
        wvalid        = 1'b0;
        bready        = 1'b0;
        araddr        = '0;
        arvalid       = 1'b0;
        rready        = 1'b0;
        ovf_event     = '0;
        lcv_ovf_event = 1'b0;
        ind_ack       = 1'b0;
        ind_rdata     = '0;
        miscompares   = 0;
        comparisons   = 0;
        starts        = 0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset_unmapped;
        t_flags0;
        t_lcv;
        t_pattern;
        t_indirect;
        test_done;
    end
endmodule : e1_perf_monitor_prbs_txpayload_regs_bench
`default_nettype wire
